// ==== clock_divider_sync_map.svh ====
// register offsets, field positions and reset values of the sync control block
`ifndef CLOCK_DIVIDER_SYNC_MAP_SVH
`define CLOCK_DIVIDER_SYNC_MAP_SVH
`define SYNC_CTRL_ADDR      13'h0100
`define OUTPUT_MODE_ADDR    13'h0014
`define SYNC_CTRL_RESET     8'h00
`define SYNC_MASTER_BIT     0
`define SYNC_DIV_EN_BIT     1
`define SYNC_FIRST_ONLY_BIT 2
`define OUT_TYPE_BIT        6
`define DIV_RATIO_DEFAULT   8
`define DIV_RATIO_MAX       8
`define STRAP_SETTLE        2
`define SYNC_CTRL_USED_MASK 8'h07
`define SYNC_MASTER_RESET   1'h0
`define SYNC_DIV_EN_RESET   1'h0
`define SYNC_FIRST_RESET    1'h0
`endif

// ==== clock_divider_sync_pkg.sv ====
// types shared by the sync control block
package clock_divider_sync_pkg;
  typedef enum logic [1:0] {
    OUT_CMOS = 2'b01,
    OUT_LVDS = 2'b10
  } out_type_t;
endpackage

// ==== int_clock_divider.sv ====
// integer input clock divider whose count restarts on an accepted sync pulse
`timescale 1ns/1ps
`default_nettype none
module int_clock_divider #(
  parameter int MAX_RATIO = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] ratio,
  input  wire logic       restart,
  output var  logic       divClk
);
  if (MAX_RATIO < 1 || MAX_RATIO > 15) begin : g_bad_max
    $error("MAX_RATIO out of range");
  end
  logic [3:0] count;
  wire  [3:0] safeRatio = (ratio == 4'h0) ? 4'h1 : ratio;
  wire        wrap      = (count >= safeRatio - 4'h1);
  wire  [3:0] next_count = (restart || wrap) ? 4'h0 : count + 4'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count  <= 4'h0;
      divClk <= 1'b0;
    end else begin
      count  <= next_count; // [RULE_11]
      divClk <= (next_count < (safeRatio >> 1)) || (safeRatio == 4'h1);
    end
  end
endmodule // int_clock_divider
`default_nettype wire

// ==== clock_divider_sync_control.sv ====
// sync control register, sync gating and output-type selection
// Notes on behaviour
// RULE_01: all sync functions ignored unless master sync enable bit 0 is set.
// RULE_02: host keeps master enable low when sync is unused, saving power.
// RULE_03: pulses reach the divider only while bits 1 and 0 are high.
// RULE_04: bits 1,0 high and bit 2 low: realign on every pulse.
// RULE_05: with bit 2 set, align to first pulse only, ignore later ones.
// RULE_06: after a first-pulse alignment, bit 1 clears itself.
// RULE_07: output type taken at power-up from the configuration pin level.
// RULE_08: LVDS may also be selected by a serial-port write.
// RULE_09: host keeps serial lines idle during critical sampling periods.
// RULE_10: sync control register resets to zero.
// RULE_11: an accepted pulse restarts the divider count.
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_sync_map.svh"
module clock_divider_sync_control #(
  parameter int DIV_RATIO = `DIV_RATIO_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [12:0] regAddr,
  input  wire logic [7:0]  regWdata,
  output var  logic [7:0]  regRdata,
  input  wire logic        syncIn,
  input  wire logic        lvdsPin,
  output var  logic        divClk,
  output var  logic        lvdsMode,
  output var  logic        syncAccepted
);

  // the divider count is four bits and the ratio is served from one to eight
  if (DIV_RATIO < 1 || DIV_RATIO > `DIV_RATIO_MAX) begin : g_bad_ratio
    $error("DIV_RATIO must be 1 to 8");
  end

  logic       master;
  logic       divEn;
  logic       firstOnly;
  logic       outTypeSpi;
  logic       strapDone;
  logic       strapLvds;
  logic [1:0] strapWait;
  logic       syncMeta;
  logic       syncSafe;
  logic       syncPrev;
  logic       pinMeta;
  logic       pinSafe;
  clock_divider_sync_pkg::out_type_t outType;

  // both pins are asynchronous: two stages before any logic reads them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMeta <= 1'b0;
    end else begin
      syncMeta <= syncIn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncSafe <= 1'b0;
    end else begin
      syncSafe <= syncMeta;
    end
  end

  // reset level matches the idle low pin, so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncPrev <= 1'b0;
    end else begin
      syncPrev <= syncSafe;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 1'b0;
    end else begin
      pinMeta <= lvdsPin;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSafe <= 1'b0;
    end else begin
      pinSafe <= pinMeta;
    end
  end

  // only a rising edge counts, so a long pulse realigns once
  wire syncEdge  = syncSafe && !syncPrev;
  wire gateOpen  = master && divEn; // [RULE_01] [RULE_03]
  wire accept    = syncEdge && gateOpen; // [RULE_04]
  wire selfClear = accept && firstOnly; // [RULE_05]

  wire addrSync  = (regAddr == `SYNC_CTRL_ADDR);
  wire addrOut   = (regAddr == `OUTPUT_MODE_ADDR);
  wire wrSync    = regWrite && addrSync;
  wire wrOut     = regWrite && addrOut;

  // reserved bits 7:3 have no storage and read as zero
  wire [7:0] wrVal = regWdata & `SYNC_CTRL_USED_MASK;
  wire [7:0] syncCtrl = {5'h00, firstOnly, divEn, master};

  wire next_master    = wrSync ? wrVal[`SYNC_MASTER_BIT] : master;
  wire next_firstOnly = wrSync ? wrVal[`SYNC_FIRST_ONLY_BIT] : firstOnly;
  // self-clear beats a same-cycle write, so a one-shot cannot re-arm silently
  wire next_divEn     = selfClear ? 1'b0 : (wrSync ? wrVal[`SYNC_DIV_EN_BIT] : divEn); // [RULE_06]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master <= `SYNC_MASTER_RESET; // [RULE_10]
    end else begin
      master <= next_master;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divEn <= `SYNC_DIV_EN_RESET; // [RULE_10]
    end else begin
      divEn <= next_divEn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstOnly <= `SYNC_FIRST_RESET; // [RULE_10]
    end else begin
      firstOnly <= next_firstOnly;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncAccepted <= 1'b0;
    end else begin
      syncAccepted <= accept;
    end
  end

  // strap caught once after reset release, when the synchroniser holds the pin level;
  // a later change of the pin is ignored until the next reset
  wire       strapTake      = !strapDone && (strapWait == 2'(`STRAP_SETTLE));
  wire [1:0] next_strapWait = strapDone ? strapWait : strapWait + 2'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapWait <= 2'h0;
    end else begin
      strapWait <= next_strapWait;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapDone <= 1'b0;
    end else if (strapTake) begin
      strapDone <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapLvds <= 1'b0;
    end else if (strapTake) begin
      strapLvds <= pinSafe; // [RULE_07]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outTypeSpi <= 1'b0;
    end else if (wrOut) begin
      outTypeSpi <= regWdata[`OUT_TYPE_BIT]; // [RULE_08]
    end
  end

  // the strap and the serial-port bit are or-ed: either one selects lvds
  assign outType = (strapLvds || outTypeSpi) ? clock_divider_sync_pkg::OUT_LVDS
                                             : clock_divider_sync_pkg::OUT_CMOS;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvdsMode <= 1'b0;
    end else begin
      lvdsMode <= (outType == clock_divider_sync_pkg::OUT_LVDS);
    end
  end

  // unmapped addresses read zero
  wire [7:0] outModeRd = {7'h00, outTypeSpi} << `OUT_TYPE_BIT;
  wire [7:0] rdMux     = addrSync ? syncCtrl :
                         addrOut  ? outModeRd :
                                    8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

  int_clock_divider #(.MAX_RATIO(`DIV_RATIO_MAX)) u_div (
    .clk     (clk),
    .rst     (rst),
    .ratio   (4'(DIV_RATIO)),
    .restart (accept), // [RULE_11]
    .divClk  (divClk)
  );
endmodule // clock_divider_sync_control
`default_nettype wire

// ==== clock_divider_sync_control_chk.sv ====
// port assertions for the sync control block
`timescale 1ns/1ps
`default_nettype none
module clock_divider_sync_control_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [12:0] regAddr,
  input wire logic [7:0]  regRdata,
  input wire logic        syncIn,
  input wire logic        divClk,
  input wire logic        lvdsMode,
  input wire logic        syncAccepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence quiet; !syncIn [*6]; endsequence
  sequence onePulse; syncAccepted ##1 !syncAccepted [*2]; endsequence
  chk_accept_spacing: assert property (syncAccepted |-> onePulse)
    else $error("accept too wide");
  chk_accept_cause: assert property (syncAccepted |-> $past(syncIn, 2) && $past(syncIn, 3))
    else $error("accept without pulse");
  chk_quiet_idle: assert property (quiet |-> !syncAccepted)
    else $error("accept while quiet");
  chk_reserved_zero: assert property (regRead && regAddr == 13'h0100 ##1 !regRead |=> regRdata[7:3] == 5'h00)
    else $error("reserved bits set");
  chk_unmapped_zero: assert property (regRead && regAddr == 13'h0030 ##1 !regRead |=> regRdata == 8'h00)
    else $error("unmapped read");
  chk_rdata_hold: assert property (!regRead [*2] |=> $stable(regRdata))
    else $error("read data moved");
  chk_divider_runs: assert property (1'b1 |-> ##[1:20] $changed(divClk))
    else $error("divider stuck");
  chk_lvds_cause: assert property ($changed(lvdsMode) |-> $past(regWrite) || $past(regWrite, 2)
    || $past(rst, 4) || $past(rst, 5) || $past(rst, 6))
    else $error("output type moved");
endmodule // clock_divider_sync_control_chk
bind clock_divider_sync_control clock_divider_sync_control_chk chk_u (.clk(clk), .rst(rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata),
  .syncIn(syncIn), .divClk(divClk), .lvdsMode(lvdsMode), .syncAccepted(syncAccepted));
`default_nettype wire

// ==== sync_pulse_src.sv ====
// external sync pulse source
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_src (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fire,
  output var  logic syncOut
);
  logic [2:0] cnt;
  // wide pulse so both synchroniser flops see it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
    end else begin
      cnt <= fire ? 3'h5 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
    end
  end
  assign syncOut = cnt != 3'h0;
endmodule // sync_pulse_src
`default_nettype wire

// ==== test_clock_divider_sync_control.sv ====
// bench for the sync control block
`timescale 1ns/1ps
`default_nettype none
module test_clock_divider_sync_control;
  logic        clk = 0, rst = 1, regWrite = 0, regRead = 0, fire = 0, lvdsPin = 0;
  logic        syncIn, lvdsMode, syncAccepted, divClk;
  logic [7:0]  divSeen = 8'h00;
  int          tail = 0;
  logic [12:0] regAddr = 13'h0000;
  logic [7:0]  regWdata = 8'h00, regRdata;
  int          err_total = 0, compares = 0, cyc = 0, hits = 0;
  clock_divider_sync_control dut_u (.clk(clk), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .syncIn(syncIn), .lvdsPin(lvdsPin), .divClk(divClk), .lvdsMode(lvdsMode),
    .syncAccepted(syncAccepted));
  sync_pulse_src src_u (.clk(clk), .rst(rst), .fire(fire), .syncOut(syncIn));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic give_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ceiling well above the ~124 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  // outputs looked at mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (syncAccepted === 1'b1) begin
      hits++;
      tail = 8;
    end
    if (tail > 0) begin
      divSeen = {divSeen[6:0], divClk};
      tail--;
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [12:0] a, logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1;
    @(posedge clk) #1 regWrite = 0;
  endtask
  task automatic rd(logic [12:0] a, logic [7:0] e);
    regAddr = a;
    regRead = 1;
    @(posedge clk) #1 regRead = 0;
    @(posedge clk) #1 check("regRdata", e, regRdata);
  endtask
  task automatic sync(logic [7:0] n);
    hits = 0;
    fire = 1;
    @(posedge clk) #1 fire = 0;
    repeat (12) @(posedge clk);
    #1 check("accepts", n, 8'(hits));
    if (n == 8'h01) check("divClk", 8'hF0, divSeen);
  endtask
  task automatic reset(logic pin);
    lvdsPin = pin;
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    repeat (6) @(posedge clk);
    #1 check("lvdsMode", {7'h00, pin}, {7'h00, lvdsMode});
  endtask
  initial begin
    reset(1'b0);
    rd(13'h0100, 8'h00);
    rd(13'h0030, 8'h00);
    sync(8'h00);
    wr(13'h0100, 8'h02);
    sync(8'h00);
    wr(13'h0100, 8'h01);
    sync(8'h00);
    wr(13'h0100, 8'h03);
    sync(8'h01);
    sync(8'h01);
    wr(13'h0100, 8'hFF);
    rd(13'h0100, 8'h07);
    sync(8'h01);
    rd(13'h0100, 8'h05);
    sync(8'h00);
    wr(13'h0014, 8'h40);
    rd(13'h0014, 8'h40);
    check("lvdsMode", 8'h01, {7'h00, lvdsMode});
    reset(1'b1);
    rd(13'h0100, 8'h00);
    give_verdict();
  end
endmodule // test_clock_divider_sync_control
`default_nettype wire
